/* File: include/pfb_pkg.sv */
// Purpose: shared constants and carriers for the peripheral flag bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per flag register
// Notes:   flag data sits in bits 7:0, upper bits read as zero
package pfb_pkg;

  // register byte offsets
  localparam logic [7:0] PFB_OFS_ONE   = 8'h00;
  localparam logic [7:0] PFB_OFS_TWO   = 8'h04;
  localparam logic [7:0] PFB_OFS_THREE = 8'h08;
  localparam logic [7:0] PFB_OFS_FOUR  = 8'h0c;

  // register indices within the bank
  localparam int unsigned PFB_IDX_ONE   = 0;
  localparam int unsigned PFB_IDX_TWO   = 1;
  localparam int unsigned PFB_IDX_THREE = 2;
  localparam int unsigned PFB_IDX_FOUR  = 3;
  localparam int unsigned PFB_NUM_REGS  = 4;

  // field positions, first register
  localparam int unsigned PFB_B1_HOST_PORT  = 7;
  localparam int unsigned PFB_B1_CONV_DONE  = 6;
  localparam int unsigned PFB_B1_UART_A_RX  = 5;
  localparam int unsigned PFB_B1_UART_A_TX  = 4;
  localparam int unsigned PFB_B1_SYNC_SER   = 3;
  localparam int unsigned PFB_B1_TMR_A_GATE = 2;
  localparam int unsigned PFB_B1_TMR_B_MTCH = 1;
  localparam int unsigned PFB_B1_TMR_A_OVF  = 0;
  // field positions, second register
  localparam int unsigned PFB_B2_CLK_FAIL   = 7;
  localparam int unsigned PFB_B2_BUS_COLL   = 3;
  localparam int unsigned PFB_B2_VOLT_LOW   = 2;
  localparam int unsigned PFB_B2_TMR_C_OVF  = 1;
  localparam int unsigned PFB_B2_TMR_C_GATE = 0;
  // field positions, third register
  localparam int unsigned PFB_B3_UART_B_RX  = 5;
  localparam int unsigned PFB_B3_UART_B_TX  = 4;
  localparam int unsigned PFB_B3_CHARGE     = 3;
  localparam int unsigned PFB_B3_CAPCOMP2   = 2;
  localparam int unsigned PFB_B3_CAPCOMP1   = 1;
  // field positions, fourth register
  localparam int unsigned PFB_B4_TMR_D_OVF  = 7;
  localparam int unsigned PFB_B4_NV_DONE    = 6;
  localparam int unsigned PFB_B4_CMP2       = 5;
  localparam int unsigned PFB_B4_CMP1       = 4;
  localparam int unsigned PFB_B4_CAPCOMP5   = 2;
  localparam int unsigned PFB_B4_CAPCOMP4   = 1;
  localparam int unsigned PFB_B4_CAPCOMP3   = 0;

  // bank layout: index 3 is the fourth register
  typedef logic [3:0][7:0] pfb_bank_t;

  // reset value, software-writable bits and implemented bits per register
  localparam pfb_bank_t PFB_RESET    = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam pfb_bank_t PFB_RW_MASK  = {8'hf7, 8'h0e, 8'h8f, 8'hcf};
  localparam pfb_bank_t PFB_IMP_MASK = {8'hf7, 8'h3e, 8'h8f, 8'hff};

  // bus answers
  localparam logic [1:0] PFB_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PFB_RESP_DECERR = 2'b11;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic host_port_access;
    logic conversion_done;
    logic sync_serial_done;
    logic timer_a_gate;
    logic timer_b_match;
    logic timer_a_overflow;
    logic clock_fail;
    logic bus_collision;
    logic voltage_low;
    logic timer_c_overflow;
    logic timer_c_gate;
    logic charge_time;
    logic [5:1] capcomp;
    logic timer_d_overflow;
    logic nv_write_done;
    logic comparator_one;
    logic comparator_two;
  } pfb_events_s;

  // uart buffer pulses: load/drain set, holding access clears
  typedef struct packed {
    logic rx_load;
    logic rx_holding_read;
    logic tx_drain;
    logic tx_holding_write;
  } pfb_uart_s;

endpackage

/* File: hw/pfb_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register logic answers reads and decode errors combinationally
// Notes:   write address and data are accepted in either order
`timescale 1ns/100ps
module pfb_axil_slave
  import pfb_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address and data
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // read address and data
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // register side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic              aw_have_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic              rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;

  // handshakes and register-side strobes
  assign s_awready = !aw_have_q && !bvalid_q;
  assign s_wready  = !w_have_q && !bvalid_q;
  assign wr_en     = aw_have_q && w_have_q && !bvalid_q;
  assign wr_addr   = awaddr_q;
  assign wr_data   = wdata_q;
  assign wr_strb   = wstrb_q;
  assign s_arready = !rvalid_q;
  assign rd_en     = s_arvalid && !rvalid_q;
  assign rd_addr   = s_araddr;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_rvalid  = rvalid_q;
  assign s_rresp   = rresp_q;
  assign s_rdata   = rdata_q;

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end else if (s_awvalid && s_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_awaddr;
    end
  end

  // write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_wdata;
      wstrb_q  <= s_wstrb;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PFB_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? PFB_RESP_DECERR : PFB_RESP_OKAY;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read response, data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= PFB_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_en) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_err ? PFB_RESP_DECERR : PFB_RESP_OKAY;
      rdata_q  <= rd_data;
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // pfb_axil_slave

/* File: hw/pfb_flag_bank.sv */
// Purpose: four peripheral interrupt request flag registers on AXI4-Lite
// Assumes: event pulses come from logic on aclk, one cycle each
// Notes:   enables, priorities and resolution live outside this bank
`timescale 1ns/100ps
module pfb_flag_bank
  import pfb_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // axi4-lite write response
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // peripheral events
  input  wire pfb_events_s       events,
  input  wire logic [5:1]        capcomp_pwm_mode,
  input  wire pfb_uart_s         uart_a,
  input  wire pfb_uart_s         uart_b,
  // flag bank to enable and priority logic
  output pfb_bank_t              flags
);

  // elaboration check on the address width
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must be 4 to 32");
  end

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic [2:0]        wr_dec;
  logic [2:0]        rd_dec;
  logic [3:0]        wr_sel;
  pfb_bank_t         set_c;
  pfb_bank_t         clr_c;
  pfb_bank_t         flags_d;
  pfb_bank_t         flags_q;

  // map a byte address to {hit, index}; low two bits ignored
  function automatic logic [2:0] pfb_decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr) & 8'hfc;
    if (addr > ADDR_W'(8'hff)) begin
      pfb_decode = 3'b000;
    end else if (a == PFB_OFS_ONE) begin
      pfb_decode = 3'b100;
    end else if (a == PFB_OFS_TWO) begin
      pfb_decode = 3'b101;
    end else if (a == PFB_OFS_THREE) begin
      pfb_decode = 3'b110;
    end else if (a == PFB_OFS_FOUR) begin
      pfb_decode = 3'b111;
    end else begin
      pfb_decode = 3'b000;
    end
  endfunction

  // next flag value: write loads writable bits, then clears, then sets win
  function automatic logic [7:0] pfb_flag_next(input logic [7:0] q, input logic wr,
                                               input logic [7:0] wd, input logic [7:0] rw,
                                               input logic [7:0] clr, input logic [7:0] set,
                                               input logic [7:0] imp);
    logic [7:0] v;
    v = wr ? ((q & ~rw) | (wd & rw)) : q;
    v = (v & ~clr) | set;
    pfb_flag_next = v & imp;
  endfunction

  // bus front end
  pfb_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_en     (rd_en),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // address decode; only byte lane 0 carries flag data
  assign wr_dec = pfb_decode(wr_addr);
  assign rd_dec = pfb_decode(rd_addr);
  assign wr_err = !wr_dec[2];
  assign rd_err = !rd_dec[2];
  assign wr_sel = (wr_en && wr_dec[2] && wr_strb[0]) ? (4'h1 << wr_dec[1:0]) : 4'h0;

  // read mux, upper bits zero, unmapped reads zero
  assign rd_data = rd_dec[2] ? {24'h00_0000, flags_q[rd_dec[1:0]] & PFB_IMP_MASK[rd_dec[1:0]]} : 32'h0000_0000;

  // event set vectors, latched with no enable gating
  always_comb begin
    set_c = '0;
    set_c[PFB_IDX_ONE][PFB_B1_HOST_PORT]    = events.host_port_access;
    set_c[PFB_IDX_ONE][PFB_B1_CONV_DONE]    = events.conversion_done;
    set_c[PFB_IDX_ONE][PFB_B1_UART_A_RX]    = uart_a.rx_load;
    set_c[PFB_IDX_ONE][PFB_B1_UART_A_TX]    = uart_a.tx_drain;
    set_c[PFB_IDX_ONE][PFB_B1_SYNC_SER]     = events.sync_serial_done;
    set_c[PFB_IDX_ONE][PFB_B1_TMR_A_GATE]   = events.timer_a_gate;
    set_c[PFB_IDX_ONE][PFB_B1_TMR_B_MTCH]   = events.timer_b_match;
    set_c[PFB_IDX_ONE][PFB_B1_TMR_A_OVF]    = events.timer_a_overflow;
    set_c[PFB_IDX_TWO][PFB_B2_CLK_FAIL]     = events.clock_fail;
    set_c[PFB_IDX_TWO][PFB_B2_BUS_COLL]     = events.bus_collision;
    set_c[PFB_IDX_TWO][PFB_B2_VOLT_LOW]     = events.voltage_low;
    set_c[PFB_IDX_TWO][PFB_B2_TMR_C_OVF]    = events.timer_c_overflow;
    set_c[PFB_IDX_TWO][PFB_B2_TMR_C_GATE]   = events.timer_c_gate;
    set_c[PFB_IDX_THREE][PFB_B3_UART_B_RX]  = uart_b.rx_load;
    set_c[PFB_IDX_THREE][PFB_B3_UART_B_TX]  = uart_b.tx_drain;
    set_c[PFB_IDX_THREE][PFB_B3_CHARGE]     = events.charge_time;
    set_c[PFB_IDX_THREE][PFB_B3_CAPCOMP2]   = events.capcomp[2] && !capcomp_pwm_mode[2];
    set_c[PFB_IDX_THREE][PFB_B3_CAPCOMP1]   = events.capcomp[1] && !capcomp_pwm_mode[1];
    set_c[PFB_IDX_FOUR][PFB_B4_TMR_D_OVF]   = events.timer_d_overflow;
    set_c[PFB_IDX_FOUR][PFB_B4_NV_DONE]     = events.nv_write_done;
    set_c[PFB_IDX_FOUR][PFB_B4_CMP2]        = events.comparator_two;
    set_c[PFB_IDX_FOUR][PFB_B4_CMP1]        = events.comparator_one;
    set_c[PFB_IDX_FOUR][PFB_B4_CAPCOMP5]    = events.capcomp[5] && !capcomp_pwm_mode[5];
    set_c[PFB_IDX_FOUR][PFB_B4_CAPCOMP4]    = events.capcomp[4] && !capcomp_pwm_mode[4];
    set_c[PFB_IDX_FOUR][PFB_B4_CAPCOMP3]    = events.capcomp[3] && !capcomp_pwm_mode[3];
  end

  // hardware clears of the uart buffer flags on holding access
  always_comb begin
    clr_c = '0;
    clr_c[PFB_IDX_ONE][PFB_B1_UART_A_RX]   = uart_a.rx_holding_read;
    clr_c[PFB_IDX_ONE][PFB_B1_UART_A_TX]   = uart_a.tx_holding_write;
    clr_c[PFB_IDX_THREE][PFB_B3_UART_B_RX] = uart_b.rx_holding_read;
    clr_c[PFB_IDX_THREE][PFB_B3_UART_B_TX] = uart_b.tx_holding_write;
  end

  // next value per register; sets beat writes and clears
  always_comb begin
    for (int i = 0; i < PFB_NUM_REGS; i++) begin
      flags_d[i] = pfb_flag_next(flags_q[i], wr_sel[i], wr_data[7:0], PFB_RW_MASK[i],
                                 clr_c[i], set_c[i], PFB_IMP_MASK[i]);
    end
  end

  // flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= PFB_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_HOST_PORT_SET: assert property (
    events.host_port_access |=> flags_q[PFB_IDX_ONE][PFB_B1_HOST_PORT])
    else $error("host port flag did not set");

  AST_CONV_STICKY: assert property (
    flags_q[PFB_IDX_ONE][PFB_B1_CONV_DONE] && !wr_sel[PFB_IDX_ONE]
      |=> flags_q[PFB_IDX_ONE][PFB_B1_CONV_DONE])
    else $error("conversion flag dropped without a write");

  AST_UART_A_RX_CLEAR: assert property (
    uart_a.rx_holding_read && !uart_a.rx_load |=> !flags_q[PFB_IDX_ONE][PFB_B1_UART_A_RX])
    else $error("uart A receive flag not cleared by holding read");

  AST_UART_B_TX_RO: assert property (
    wr_sel[PFB_IDX_THREE] && !uart_b.tx_drain && !uart_b.tx_holding_write
      |=> flags_q[PFB_IDX_THREE][PFB_B3_UART_B_TX] == $past(flags_q[PFB_IDX_THREE][PFB_B3_UART_B_TX]))
    else $error("uart B transmit flag changed by a bus write");

  AST_SECOND_STICKY: assert property (
    !wr_sel[PFB_IDX_TWO] |=> (($past(flags_q[PFB_IDX_TWO]) & ~flags_q[PFB_IDX_TWO]) == 8'h00))
    else $error("second register flag fell without a write");

  AST_UNIMPL_ZERO: assert property (
    rd_en && rd_dec == 3'b110 |-> rd_data[7:6] == 2'b00 && rd_data[0] == 1'b0 && rd_data[31:8] == 24'h00_0000)
    else $error("unimplemented bits of third register read nonzero");

  AST_PWM_SUPPRESS: assert property (
    !flags_q[PFB_IDX_THREE][PFB_B3_CAPCOMP1] && !wr_sel[PFB_IDX_THREE] && capcomp_pwm_mode[1]
      ##0 events.capcomp[1] |=> !flags_q[PFB_IDX_THREE][PFB_B3_CAPCOMP1])
    else $error("capture compare one set while in pwm mode");

  AST_NV_DONE_SET: assert property (
    events.nv_write_done |=> flags_q[PFB_IDX_FOUR][PFB_B4_NV_DONE] ##1
      (flags_q[PFB_IDX_FOUR][PFB_B4_NV_DONE] || $past(wr_sel[PFB_IDX_FOUR])))
    else $error("write-done flag not held");

  AST_SET_WINS: assert property (
    wr_sel[PFB_IDX_ONE] && !wr_data[PFB_B1_TMR_A_OVF] && events.timer_a_overflow
      |=> flags_q[PFB_IDX_ONE][PFB_B1_TMR_A_OVF])
    else $error("event lost against a clearing write");

  AST_WRITE_LOADS: assert property (
    wr_sel[PFB_IDX_FOUR] && set_c[PFB_IDX_FOUR] == 8'h00
      |=> flags_q[PFB_IDX_FOUR] == ($past(wr_data[7:0]) & PFB_RW_MASK[PFB_IDX_FOUR]))
    else $error("fourth register did not load the written value");

endmodule // pfb_flag_bank

/* File: dv/tb_peripheral_irq_flag_bank.sv */
// Purpose: self-checking bench for the peripheral flag bank
// Assumes: flags reached through axi4-lite, events as one-cycle pulses
// Notes:   driver queues expected answers, monitor pops one at each response
`timescale 1ns/100ps
module tb_peripheral_irq_flag_bank
  import pfb_pkg::*;
;
  // clock, reset, bus and event signals
  logic        aclk, aresetn;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [5:1]  pwm;
  pfb_events_s ev;
  pfb_uart_s   ua_s, ub_s;
  pfb_bank_t   flags, bank;
  logic [33:0] rq[$];
  logic [1:0]  wq[$];
  logic [20:0] vec;
  logic [31:0] wd;
  integer      seed, err_count, checks_done, i, r, p;
  // event bit to {register, bit}
  localparam logic [4:0] EV_MAP [0:20] = '{5'h1d, 5'h1c, 5'h1e, 5'h1f, 5'h11, 5'h12, 5'h18, 5'h19, 5'h1a, 5'h13,
                                          5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0f, 5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07};

  pfb_flag_bank DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .events(ev), .capcomp_pwm_mode(pwm), .uart_a(ua_s), .uart_b(ub_s), .flags(flags));

  // 10 mhz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // compare one answer against its note
  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] resp);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    wq.push_back(resp);
    @(posedge aclk);
    s_awaddr  <= a;
    s_awvalid <= 1'b1;
    s_wdata   <= d;
    s_wstrb   <= st;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_awready) begin
        aw_p = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w_p && s_wready) begin
        w_p = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge aclk);
    s_bready <= 1'b0;
  endtask

  // read: address held until taken, rready until the answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    rq.push_back({resp, d});
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    @(posedge aclk);
    while (!s_arready) @(posedge aclk);
    s_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_rvalid) @(posedge aclk);
    s_rready <= 1'b0;
  endtask

  // one-cycle pulse on events and uart strobes
  task automatic pulse(input logic [20:0] v, input logic [3:0] ua, input logic [3:0] ub);
    @(posedge aclk);
    ev   <= pfb_events_s'(v);
    ua_s <= pfb_uart_s'(ua);
    ub_s <= pfb_uart_s'(ub);
    @(posedge aclk);
    ev   <= '0;
    ua_s <= '0;
    ub_s <= '0;
  endtask

  // monitor: take the oldest note at each response
  always @(posedge aclk) begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1) cmp("read answer", rq.pop_front(), {s_rresp, s_rdata});
    if (s_bvalid === 1'b1 && s_bready === 1'b1) cmp("write answer", {32'h0, wq.pop_front()}, {32'h0, s_bresp});
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("unexpected run length: expected completion, seen hang");
    stop_test;
  end

  // main sequence
  initial begin
    seed = 32'h8d62;
    err_count = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, pwm} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    ev = '0;
    ua_s = '0;
    ub_s = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h10, 32'hff, 4'hf, PFB_RESP_DECERR);
    rd(8'h10, 32'h0, PFB_RESP_DECERR);
    for (r = 0; r < 4; r++) rd(8'(r * 4), 32'h0, PFB_RESP_OKAY);
    cmp("flag bank", 34'h0, {2'b00, flags});
    $display("test reset values done");
    for (p = 0; p < 2; p++) begin
      for (r = 0; r < 4; r++) begin
        wd = (p == 0) ? 32'hff : $random(seed);
        wr(8'(r * 4), wd, 4'hf, PFB_RESP_OKAY);
        rd(8'(r * 4), {24'h0, wd[7:0] & PFB_RW_MASK[r]}, PFB_RESP_OKAY);
        wr(8'(r * 4), 32'h0, 4'he, PFB_RESP_OKAY);
        rd(8'(r * 4), {24'h0, wd[7:0] & PFB_RW_MASK[r]}, PFB_RESP_OKAY);
        wr(8'(r * 4), 32'h0, 4'hf, PFB_RESP_OKAY);
      end
    end
    $display("test software writes done");
    for (i = 0; i < 21; i++) begin
      pulse(21'h1 << i, 4'h0, 4'h0);
      rd({4'h0, EV_MAP[i][4:3], 2'h0}, 32'h1 << EV_MAP[i][2:0], PFB_RESP_OKAY);
      wr({4'h0, EV_MAP[i][4:3], 2'h0}, 32'h0, 4'hf, PFB_RESP_OKAY);
      rd({4'h0, EV_MAP[i][4:3], 2'h0}, 32'h0, PFB_RESP_OKAY);
    end
    pwm <= 5'h1f;
    pulse(21'h1f0, 4'h0, 4'h0);
    rd(8'h08, 32'h0, PFB_RESP_OKAY);
    rd(8'h0c, 32'h0, PFB_RESP_OKAY);
    pwm <= 5'h00;
    vec = 21'($random(seed));
    pulse(vec, 4'h0, 4'h0);
    bank = '0;
    for (i = 0; i < 21; i++) if (vec[i]) bank[EV_MAP[i][4:3]][EV_MAP[i][2:0]] = 1'b1;
    for (r = 0; r < 4; r++) rd(8'(r * 4), {24'h0, bank[r]}, PFB_RESP_OKAY);
    cmp("flag bank", {2'b00, bank}, {2'b00, flags});
    for (r = 0; r < 4; r++) wr(8'(r * 4), 32'h0, 4'hf, PFB_RESP_OKAY);
    $display("test peripheral events done");
    pulse(21'h100000, 4'h0, 4'h0);
    fork
      wr(8'h00, 32'h0, 4'hf, PFB_RESP_OKAY);
      begin
        @(posedge aclk iff (s_awvalid && s_awready));
        ev <= pfb_events_s'(21'h108000);
        @(posedge aclk);
        ev <= '0;
      end
    join
    rd(8'h00, 32'h81, PFB_RESP_OKAY);
    wr(8'h00, 32'h0, 4'hf, PFB_RESP_OKAY);
    $display("test event over clear done");
    for (r = 0; r < 4; r += 2) begin
      pulse(21'h0, (r == 0) ? 4'ha : 4'h0, (r == 2) ? 4'ha : 4'h0);
      rd(8'(r * 4), 32'h30, PFB_RESP_OKAY);
      wr(8'(r * 4), 32'h0, 4'hf, PFB_RESP_OKAY);
      rd(8'(r * 4), 32'h30, PFB_RESP_OKAY);
      pulse(21'h0, (r == 0) ? 4'h7 : 4'h0, (r == 2) ? 4'h7 : 4'h0);
      rd(8'(r * 4), 32'h10, PFB_RESP_OKAY);
      pulse(21'h0, (r == 0) ? 4'hd : 4'h0, (r == 2) ? 4'hd : 4'h0);
      rd(8'(r * 4), 32'h20, PFB_RESP_OKAY);
      pulse(21'h0, (r == 0) ? 4'h4 : 4'h0, (r == 2) ? 4'h4 : 4'h0);
      rd(8'(r * 4), 32'h0, PFB_RESP_OKAY);
    end
    $display("test uart flags done");
    stop_test;
  end
endmodule // tb_peripheral_irq_flag_bank
